// [halt_mode_controller.v]
/*
 Standby (halt) controller with an AHB-Lite register slave. Stops the CPU
 in one of three standby levels, gates clock domains and pin buffers, and
 restarts on interrupt with an oscillator warm-up after the deepest level.
 Assumes the CPU pulses i_halt_exec once per halt instruction, and that
 i_clock is the free-running oscillator clock while it is enabled.
*/
`timescale 1ns/1ps
`include "halt_consts.vh"

module halt_mode_controller #(
   parameter [`WARMUP_CNT_W-1:0] WARMUP_MID_CYCLES = `WARMUP_MID_CYC,
   parameter [`WARMUP_CNT_W-1:0] WARMUP_LONG_CYCLES = `WARMUP_LONG_CYC
) (
   // Clock and reset
   input wire i_clock,
   input wire i_rst_n,
   // AHB-Lite slave
   input wire i_hsel,
   input wire [7:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output reg o_hreadyout,
   output reg o_hresp,
   // CPU and interrupt controller
   input wire i_halt_exec,
   input wire i_irq_req,
   input wire [2:0] i_irq_level,
   input wire [2:0] i_irq_mask,
   input wire i_ext_irq_zero,
   // Standby controls
   output reg o_cpu_hold,
   output reg o_sys_clk_en,
   output reg o_osc_en,
   output reg o_rtc_en,
   output reg o_melody_en,
   output reg [`PERIPH_W-1:0] o_periph_en,
   output reg o_pin_hold,
   output reg o_pin_cond_b,
   output reg o_irq_service,
   output reg o_halted
);

   ////////////////////////////////////////////////////////////////////////
   // States

   localparam [5:0] ST_RUN = 6'h01;
   localparam [5:0] ST_LIGHT = 6'h02;
   localparam [5:0] ST_MID = 6'h04;
   localparam [5:0] ST_DEEP = 6'h08;
   localparam [5:0] ST_WARM = 6'h10;
   localparam [5:0] ST_RESUME = 6'h20;

   // Warm-up time to cycle figures at the high-speed clock rate
   localparam [31:0] SHORT_FROM_NS =
      (`WARMUP_SHORT_NS * (`HSCLK_KHZ / 1000)) / 1000;
   localparam [31:0] MID_FROM_NS =
      (`WARMUP_MID_NS * (`HSCLK_KHZ / 1000)) / 1000;
   localparam [31:0] LONG_FROM_NS =
      (`WARMUP_LONG_NS * (`HSCLK_KHZ / 1000)) / 1000;

   reg [5:0] state_q;
   reg [5:0] state_d;
   reg [`PC_WIDTH-1:0] power_control_q;
   reg [`PERIPH_W-1:0] light_periph_q;
   reg irq_meta_q;
   reg irq_sync_q;
   reg ext0_meta_q;
   reg ext0_sync_q;
   reg service_pending_q;
   reg warm_start_q;
   reg addr_valid_q;
   reg addr_write_q;
   reg [7:0] addr_q;

   wire [1:0] level_sel;
   wire [1:0] warmup_sel;
   wire drive_bit;
   wire seldrv_bit;
   wire irq_unmasked;
   wire wake_any;
   wire warm_busy;
   wire warm_done;
   wire addr_phase;

   assign level_sel = power_control_q[`PC_LEVEL_MSB:`PC_LEVEL_LSB];
   assign warmup_sel = power_control_q[`PC_WARMUP_MSB:`PC_WARMUP_LSB];
   assign drive_bit = power_control_q[`PC_DRIVE_BIT];
   assign seldrv_bit = power_control_q[`PC_SELDRV_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Pin condition B for a level; deep level only looks at the drive bit
   function pin_cond_b;
      input deep;
      input drve;
      input seldrv;
      begin
         if (deep)
            pin_cond_b = drve;
         else
            pin_cond_b = drve | ~seldrv;
      end
   endfunction

   // Standby state selected by the level code
   function [5:0] level_state;
      input [1:0] code;
      begin
         case (code)
            `LEVEL_LIGHT: level_state = ST_LIGHT;
            `LEVEL_MID: level_state = ST_MID;
            `LEVEL_DEEP: level_state = ST_DEEP;
            default: level_state = ST_RUN;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Wake detection on the oscillator clock

   // Runs on the free oscillator clock, not the gated system clock, so a
   // request is seen even while the CPU clock is stopped
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_meta_q <= 1'b0;
         irq_sync_q <= 1'b0;
         ext0_meta_q <= 1'b0;
         ext0_sync_q <= 1'b0;
      end else begin
         irq_meta_q <= i_irq_req;
         irq_sync_q <= irq_meta_q;
         ext0_meta_q <= i_ext_irq_zero;
         ext0_sync_q <= ext0_meta_q;
      end
   end

   // Level and mask come from logic on this clock
   assign irq_unmasked = irq_sync_q & (i_irq_level > i_irq_mask);
   assign wake_any = irq_unmasked | ext0_sync_q;

   ////////////////////////////////////////////////////////////////////////
   // Warm-up counter

   warmup_counter #(
      .MID_CYCLES(WARMUP_MID_CYCLES),
      .LONG_CYCLES(WARMUP_LONG_CYCLES)
   ) u_warmup (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_start(warm_start_q),
      .i_sel(warmup_sel),
      .o_busy(warm_busy),
      .o_done(warm_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // State machine

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (i_halt_exec)
               state_d = level_state(level_sel);
         end
         ST_LIGHT: begin
            if (wake_any)
               state_d = ST_RESUME;
         end
         ST_MID: begin
            if (wake_any)
               state_d = ST_RESUME;
         end
         ST_DEEP: begin
            if (wake_any)
               state_d = ST_WARM;
         end
         ST_WARM: begin
            if (warm_done)
               state_d = ST_RESUME;
         end
         ST_RESUME: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_RUN;
         warm_start_q <= 1'b0;
         service_pending_q <= 1'b0;
      end else begin
         state_q <= state_d;
         warm_start_q <= (state_q == ST_DEEP) && wake_any;
         // Note whether release came from an unmasked request
         if ((state_q == ST_LIGHT || state_q == ST_MID ||
              state_q == ST_DEEP) && wake_any)
            service_pending_q <= irq_unmasked;
         else if (state_q == ST_RESUME)
            service_pending_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control outputs, registered from the next state; o_irq_service from the current state

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cpu_hold <= 1'b0;
         o_sys_clk_en <= 1'b1;
         o_osc_en <= 1'b1;
         o_rtc_en <= 1'b1;
         o_melody_en <= 1'b1;
         o_periph_en <= {`PERIPH_W{1'b1}};
         o_pin_hold <= 1'b0;
         o_pin_cond_b <= 1'b0;
         o_irq_service <= 1'b0;
         o_halted <= 1'b0;
      end else begin
         o_irq_service <= (state_q == ST_RESUME) && service_pending_q;
         case (state_d)
            ST_LIGHT: begin
               o_cpu_hold <= 1'b1;
               o_sys_clk_en <= 1'b1;
               o_osc_en <= 1'b1;
               o_rtc_en <= 1'b1;
               o_melody_en <= 1'b1;
               o_periph_en <= light_periph_q;
               o_pin_hold <= 1'b0;
               o_halted <= 1'b1;
            end
            ST_MID: begin
               o_cpu_hold <= 1'b1;
               o_sys_clk_en <= 1'b0;
               o_osc_en <= 1'b1;
               o_rtc_en <= 1'b1;
               o_melody_en <= 1'b1;
               o_periph_en <= {`PERIPH_W{1'b0}};
               o_pin_hold <= 1'b1;
               o_pin_cond_b <= pin_cond_b(1'b0, drive_bit,
                  seldrv_bit);
               o_halted <= 1'b1;
            end
            ST_DEEP: begin
               o_cpu_hold <= 1'b1;
               o_sys_clk_en <= 1'b0;
               o_osc_en <= 1'b0;
               o_rtc_en <= 1'b0;
               o_melody_en <= 1'b0;
               o_periph_en <= {`PERIPH_W{1'b0}};
               o_pin_hold <= 1'b1;
               o_pin_cond_b <= pin_cond_b(1'b1, drive_bit,
                  seldrv_bit);
               o_halted <= 1'b1;
            end
            ST_WARM: begin
               // Oscillator back on, everything else waits for it
               o_cpu_hold <= 1'b1;
               o_sys_clk_en <= 1'b0;
               o_osc_en <= 1'b1;
               o_rtc_en <= 1'b0;
               o_melody_en <= 1'b0;
               o_periph_en <= {`PERIPH_W{1'b0}};
               o_pin_hold <= 1'b1;
               o_halted <= 1'b1;
            end
            ST_RESUME: begin
               // Clock back first, CPU released one edge later
               o_cpu_hold <= 1'b1;
               o_sys_clk_en <= 1'b1;
               o_osc_en <= 1'b1;
               o_rtc_en <= 1'b1;
               o_melody_en <= 1'b1;
               o_periph_en <= {`PERIPH_W{1'b1}};
               o_pin_hold <= 1'b0;
               o_halted <= 1'b1;
            end
            default: begin
               o_cpu_hold <= 1'b0;
               o_sys_clk_en <= 1'b1;
               o_osc_en <= 1'b1;
               o_rtc_en <= 1'b1;
               o_melody_en <= 1'b1;
               o_periph_en <= {`PERIPH_W{1'b1}};
               o_pin_hold <= 1'b0;
               o_halted <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY

   assign addr_phase = i_hsel & i_htrans[1] & i_hready;

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_valid_q <= 1'b0;
         addr_write_q <= 1'b0;
         addr_q <= 8'h00;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= 32'h00000000;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         if (i_hready) begin
            addr_valid_q <= addr_phase;
            addr_write_q <= i_hwrite;
            addr_q <= i_haddr;
         end
         // Read data captured at the address phase; unmapped reads zero
         if (addr_phase && !i_hwrite) begin
            case (i_haddr)
               `OFS_POWER_CONTROL:
                  o_hrdata <= {26'h0000000, power_control_q};
               `OFS_LIGHT_PERIPH:
                  o_hrdata <= {24'h000000, light_periph_q};
               `OFS_STATUS:
                  o_hrdata <= {25'h0000000, warm_busy, state_q};
               default:
                  o_hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Writes during the data phase; unmapped and status writes ignored
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         power_control_q <= `PC_RESET;
         light_periph_q <= `LIGHT_PERIPH_RESET;
      end else if (addr_valid_q && addr_write_q) begin
         case (addr_q)
            `OFS_POWER_CONTROL:
               power_control_q <= i_hwdata[`PC_WIDTH-1:0];
            `OFS_LIGHT_PERIPH:
               light_periph_q <= i_hwdata[`PERIPH_W-1:0];
            default: begin
               power_control_q <= power_control_q;
            end
         endcase
      end
   end

endmodule // halt_mode_controller

// [halt_consts.vh]
/*
 Offsets, field positions, reset values and timing counts shared by the
 standby controller and its warm-up counter.
 Assumes a byte-addressed AHB-Lite slave with 32-bit data.
*/
`ifndef HALT_CONSTS_VH
`define HALT_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_POWER_CONTROL 8'h00
`define OFS_LIGHT_PERIPH 8'h04
`define OFS_STATUS 8'h08

////////////////////////////////////////////////////////////////////////
// power_control_reg fields
`define PC_LEVEL_LSB 0
`define PC_LEVEL_MSB 1
`define PC_WARMUP_LSB 2
`define PC_WARMUP_MSB 3
`define PC_DRIVE_BIT 4
`define PC_SELDRV_BIT 5
`define PC_WIDTH 6
`define PC_RESET 6'h0B

////////////////////////////////////////////////////////////////////////
// Standby level codes
`define LEVEL_LIGHT 2'h3
`define LEVEL_MID 2'h2
`define LEVEL_DEEP 2'h1

////////////////////////////////////////////////////////////////////////
// Warm-up select codes and lengths in oscillator cycles
`define WARMUP_SHORT 2'h1
`define WARMUP_MID 2'h2
`define WARMUP_LONG 2'h3
`define WARMUP_SHORT_CYC 17'h00100
`define WARMUP_MID_CYC 17'h04000
`define WARMUP_LONG_CYC 17'h10000
`define WARMUP_CNT_W 17

// Warm-up times with the 40 MHz high-speed clock as source
`define HSCLK_KHZ 40000
`define WARMUP_SHORT_NS 6400
`define WARMUP_MID_NS 409600
`define WARMUP_LONG_NS 1638000

////////////////////////////////////////////////////////////////////////
// Peripheral enables in the lightest level
`define PERIPH_W 8
`define LIGHT_PERIPH_RESET 8'h00

`endif

// [warmup_counter.v]
/*
 Oscillator warm-up counter: counts oscillator cycles from a start pulse
 up to the length chosen by the two-bit select, then raises done.
 Assumes the clock is the oscillator output itself.
*/
`timescale 1ns/1ps
`include "halt_consts.vh"

module warmup_counter #(
   parameter [`WARMUP_CNT_W-1:0] MID_CYCLES = `WARMUP_MID_CYC,
   parameter [`WARMUP_CNT_W-1:0] LONG_CYCLES = `WARMUP_LONG_CYC
) (
   // Clock and reset
   input wire i_clock,
   input wire i_rst_n,
   // Control
   input wire i_start,
   input wire [1:0] i_sel,
   // Status
   output reg o_busy,
   output reg o_done
);

   reg [`WARMUP_CNT_W-1:0] count_q;
   reg [`WARMUP_CNT_W-1:0] limit_q;
   reg [`WARMUP_CNT_W-1:0] limit_d;

   // Code 00 has no documented length; the shortest one is used
   always @* begin
      case (i_sel)
         `WARMUP_MID: limit_d = MID_CYCLES;
         `WARMUP_LONG: limit_d = LONG_CYCLES;
         default: limit_d = `WARMUP_SHORT_CYC;
      endcase
   end

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_q <= 17'h00000;
         limit_q <= 17'h00000;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            count_q <= 17'h00001;
            limit_q <= limit_d;
            o_busy <= 1'b1;
         end else if (o_busy) begin
            if (count_q == limit_q) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end else begin
               count_q <= count_q + 17'h00001;
            end
         end
      end
   end

endmodule // warmup_counter

// [halt_mode_controller_asserts.sv]
/* Port checker for the standby controller.
 Assumes one clock and the async active-low reset of the top module. */
`timescale 1ns/1ps
module halt_mode_controller_asserts #(
   parameter [16:0] WARMUP_MID_CYCLES = 17'h04000,
   parameter [16:0] WARMUP_LONG_CYCLES = 17'h10000
) (
   // Clock, reset, CPU side
   input wire i_clock,
   input wire i_rst_n,
   input wire i_halt_exec,
   input wire i_irq_req,
   input wire [2:0] i_irq_level,
   input wire [2:0] i_irq_mask,
   input wire i_ext_irq_zero,
   // Standby controls
   input wire o_cpu_hold,
   input wire o_sys_clk_en,
   input wire o_osc_en,
   input wire o_rtc_en,
   input wire o_melody_en,
   input wire [7:0] o_periph_en,
   input wire o_pin_hold,
   input wire o_irq_service,
   input wire o_halted
);
   // Shortest warm-up of any code, assuming mid below long
   localparam int MINW = (WARMUP_MID_CYCLES < 256) ? WARMUP_MID_CYCLES : 256;
   wire wake = i_ext_irq_zero | (i_irq_req & (i_irq_level > i_irq_mask));
   logic deep_q;
   logic [16:0] warm_q;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         deep_q <= 1'b0;
         warm_q <= 17'h00000;
      end else begin
         deep_q <= (deep_q | ~o_osc_en) & ~o_sys_clk_en;
         warm_q <= (deep_q & o_osc_en & ~o_sys_clk_en) ? warm_q + 17'h00001
                                                     : 17'h00000;
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // Six quiet cycles flush the two-stage synchroniser
   sequence s_deep_quiet;
      (!o_osc_en && !wake) [*6];
   endsequence
   sequence s_deep_woken;
      (!o_osc_en && wake) [*3];
   endsequence
   a_halt_cause: assert property (
      $rose(o_halted) |-> $past(i_halt_exec)) else $error("halt unasked");
   a_deep_off: assert property (
      !o_osc_en |-> !o_rtc_en && !o_melody_en && !o_sys_clk_en
      && o_periph_en == 8'h00 && o_cpu_hold) else $error("deep not off");
   a_pin_stopped: assert property (
      o_pin_hold |-> o_halted && !o_sys_clk_en) else $error("pin hold");
   a_gate_holds_cpu: assert property (
      o_halted && !o_sys_clk_en |-> o_cpu_hold) else $error("cpu free");
   a_no_false_wake: assert property (
      s_deep_quiet |=> !o_osc_en) else $error("woke with no cause");
   a_deep_wake: assert property (
      s_deep_woken |-> ##[0:4] o_osc_en) else $error("wake missed");
   a_resume_order: assert property (
      $fell(o_halted) |-> $past(o_sys_clk_en) && $past(o_cpu_hold))
      else $error("resume order");
   a_service_exit: assert property (
      o_irq_service |-> !o_halted && $past(o_halted)) else $error("service");
   a_warm_length: assert property (
      $rose(o_sys_clk_en) && deep_q |-> warm_q >= MINW - 1)
      else $error("warm-up short");
   a_reset_state: assert property (
      disable iff (1'b0) !i_rst_n |-> o_sys_clk_en && !o_halted
      && !o_cpu_hold && o_osc_en) else $error("reset state");
endmodule // halt_mode_controller_asserts
bind halt_mode_controller halt_mode_controller_asserts #(
   .WARMUP_MID_CYCLES(WARMUP_MID_CYCLES),
   .WARMUP_LONG_CYCLES(WARMUP_LONG_CYCLES)
) u_asserts (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_halt_exec(i_halt_exec), .i_irq_req(i_irq_req),
   .i_irq_level(i_irq_level), .i_irq_mask(i_irq_mask),
   .i_ext_irq_zero(i_ext_irq_zero), .o_cpu_hold(o_cpu_hold),
   .o_sys_clk_en(o_sys_clk_en), .o_osc_en(o_osc_en), .o_rtc_en(o_rtc_en),
   .o_melody_en(o_melody_en), .o_periph_en(o_periph_en),
   .o_pin_hold(o_pin_hold), .o_irq_service(o_irq_service),
   .o_halted(o_halted));

// [cpu_irq_model.sv]
/* CPU core and interrupt controller model facing the standby block.
 Assumes the bench calls its tasks; requests stay up until dropped. */
`timescale 1ns/1ps
module cpu_irq_model (
   input wire i_clock,
   output reg o_halt_exec,
   output reg o_irq_req,
   output reg [2:0] o_irq_level,
   output reg [2:0] o_irq_mask,
   output reg o_ext_irq_zero
);
   initial begin
      o_halt_exec = 1'b0;
      o_irq_req = 1'b0;
      o_irq_level = 3'h0;
      o_irq_mask = 3'h7;
      o_ext_irq_zero = 1'b0;
   end
   task halt;
      @(posedge i_clock);
      o_halt_exec <= 1'b1;
      @(posedge i_clock);
      o_halt_exec <= 1'b0;
   endtask
   // Lag puts the request off the clock edge, as a real pin would
   task irq(input [2:0] lvl, input [2:0] msk, input int lag);
      @(posedge i_clock);
      o_irq_level <= lvl;
      o_irq_mask <= msk;
      #(lag) o_irq_req <= 1'b1;
   endtask
   task ext(input int lag);
      @(posedge i_clock);
      #(lag) o_ext_irq_zero <= 1'b1;
   endtask
   task drop;
      @(posedge i_clock);
      o_irq_req <= 1'b0;
      o_ext_irq_zero <= 1'b0;
   endtask
endmodule // cpu_irq_model

// [halt_mode_controller_bench.sv]
/* Self-checking bench for the standby controller.
 Assumes the AHB slave answers with hreadyout and the CPU model above. */
`timescale 1ns/1ps
`include "halt_consts.vh"
module halt_mode_controller_bench;
   localparam [16:0] MIDC = 17'h00014;
   localparam [16:0] LONGC = 17'h00028;
   logic i_clock, i_rst_n, hsel, hwrite;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, rd, p;
   wire [31:0] hrdata;
   wire [2:0] lvl, msk;
   wire [7:0] periph;
   wire hready, hresp, hexec, ireq, ext0, hold, sclk, osc, rtc, mel, pinh;
   wire pinb, srv, halted;
   int bad_count, checks_done, seed, n, k, d;
   halt_mode_controller #(.WARMUP_MID_CYCLES(MIDC),
      .WARMUP_LONG_CYCLES(LONGC)) u_dut (.i_clock(i_clock),
      .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .i_halt_exec(hexec), .i_irq_req(ireq),
      .i_irq_level(lvl), .i_irq_mask(msk), .i_ext_irq_zero(ext0),
      .o_cpu_hold(hold), .o_sys_clk_en(sclk), .o_osc_en(osc),
      .o_rtc_en(rtc), .o_melody_en(mel), .o_periph_en(periph),
      .o_pin_hold(pinh), .o_pin_cond_b(pinb), .o_irq_service(srv),
      .o_halted(halted));
   cpu_irq_model u_cpu (.i_clock(i_clock), .o_halt_exec(hexec),
      .o_irq_req(ireq), .o_irq_level(lvl), .o_irq_mask(msk),
      .o_ext_irq_zero(ext0));
   always #50 i_clock = ~i_clock;
   ////////////////////////////////////////////////////////////////////
   task check(input [31:0] got, input [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task check_range(input [31:0] got, input [31:0] lo, input [31:0] hi);
      checks_done++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, lo);
      end
   endtask
   task xfer(input w, input [7:0] a, input [31:0] wd);
      @(posedge i_clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge i_clock);
      while (hready !== 1'b1) @(posedge i_clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge i_clock);
      while (hready !== 1'b1) @(posedge i_clock);
      rd = hrdata;
   endtask
   task tick(input int c);
      repeat (c) @(negedge i_clock);
   endtask
   task await_run;
      for (n = 0; n < 600 && halted !== 1'b0; n++) @(negedge i_clock);
      check(halted, 1'b0);
   endtask
   function [31:0] warm_len(input [1:0] c);
      warm_len = (c == `WARMUP_MID) ? MIDC : (c == `WARMUP_LONG) ? LONGC
                 : `WARMUP_SHORT_CYC;
   endfunction
   function pin_b_exp(input deep, input drv, input sel);
      pin_b_exp = deep ? drv : (drv | ~sel);
   endfunction
   task give_verdict;
      if (bad_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      #3000000;
      bad_count++;
      give_verdict;
   end
   initial begin
      i_clock = 1'b0;
      i_rst_n = 1'b1;
      {hsel, hwrite, haddr, htrans, hwdata} = '0;
      {bad_count, checks_done} = '0;
      seed = 46050;
      // Reset falls after time zero so every reset process sees the edge
      #1 i_rst_n = 1'b0;
      repeat (8) @(posedge i_clock);
      i_rst_n <= 1'b1;
      tick(1);
      check({sclk, osc, halted, hold, periph}, 12'hCFF);
      xfer(0, `OFS_POWER_CONTROL, 0);
      check(rd, `PC_RESET);
      check(hresp, 1'b0);
      xfer(0, `OFS_LIGHT_PERIPH, 0);
      check(rd, `LIGHT_PERIPH_RESET);
      xfer(1, `OFS_STATUS, 32'hFFFFFFFF);
      xfer(0, `OFS_STATUS, 0);
      check(rd, 32'h00000001);
      xfer(0, 8'h0C, 0);
      check(rd, 32'h00000000);
      // Level code 00 must not halt
      xfer(1, `OFS_POWER_CONTROL, 32'h00000004);
      u_cpu.halt;
      tick(3);
      check(halted, 1'b0);
      p = $random(seed) & 32'hFF;
      xfer(1, `OFS_LIGHT_PERIPH, p);
      xfer(1, `OFS_POWER_CONTROL, 32'h00000007);
      u_cpu.halt;
      tick(2);
      check(periph, p[7:0]);
      check({hold, sclk, pinh}, 3'h6);
      u_cpu.irq(3'h2, 3'h2, 0);
      tick(8);
      check(halted, 1'b1);
      u_cpu.drop;
      fork
         u_cpu.irq(3'h5, 3'h1, 30);
         begin
            for (k = 0; k < 40 && srv !== 1'b1; k++) @(negedge i_clock);
            check(srv, 1'b1);
         end
      join
      await_run;
      u_cpu.drop;
      for (k = 0; k < 4; k++) begin
         xfer(1, `OFS_POWER_CONTROL, {k[1:0], 4'h6});
         u_cpu.halt;
         tick(2);
         check(sclk, 1'b0);
         check({osc, rtc, mel, periph}, 11'h700);
         check({pinh, pinb}, {1'b1, pin_b_exp(0, k[0], k[1])});
         u_cpu.ext(37);
         await_run;
         u_cpu.drop;
      end
      for (k = 0; k < 4; k++) begin
         d = $random(seed) & 3;
         xfer(1, `OFS_POWER_CONTROL, {d[1:0], k[1:0], `LEVEL_DEEP});
         u_cpu.halt;
         tick(2);
         check(osc, 1'b0);
         check(pinb, pin_b_exp(1, d[0], d[1]));
         u_cpu.irq(3'h6, 3'h0, 61);
         for (n = 0; n < 20 && osc !== 1'b1; n++) @(negedge i_clock);
         check(osc, 1'b1);
         for (n = 0; n < 400 && sclk !== 1'b1; n++) @(negedge i_clock);
         check_range(n, warm_len(k), warm_len(k) + 3);
         // Code 01 time at the 40 MHz high-speed clock rate
         d = n * (1000000 / `HSCLK_KHZ);
         if (k == 1)
            check_range(d, `WARMUP_SHORT_NS, `WARMUP_SHORT_NS + 75);
         await_run;
         u_cpu.drop;
      end
      // Reset lands between edges, while the mid level is held
      xfer(1, `OFS_POWER_CONTROL, 32'h00000006);
      u_cpu.halt;
      tick(2);
      #10 i_rst_n = 1'b0;
      #10 check({halted, hold, sclk}, 3'h1);
      @(posedge i_clock);
      i_rst_n <= 1'b1;
      xfer(0, `OFS_POWER_CONTROL, 0);
      check(rd, `PC_RESET);
      give_verdict;
   end
endmodule // halt_mode_controller_bench
